// ==== tb/pcfg_rd_src.sv ====
`timescale 1ns/1ps
// Sensing front end: a one-cycle strobe carries each raw reading. Between
// strobes the data lines churn, so a stale value is never mistaken for one.
module pcfg_rd_src (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic [23:0] i_val,
  output logic             o_valid,
  output logic [23:0]      o_data
);
  logic [23:0] churn = 24'h5a5a5a;
  always_ff @(posedge i_clk) begin
    churn   <= churn + 24'h03c1e7;
    o_valid <= i_go;
    o_data  <= i_go ? i_val : churn;
  end
endmodule : pcfg_rd_src

// ==== tb/tb_pressure_config_cmd_interp.sv ====
`timescale 1ns/1ps
module tb_pressure_config_cmd_interp;
  import pcfg_pkg::*;
  // Version code value is arbitrary.
  localparam logic [7:0] VER = 8'h11;
  logic               clk = 1'b0;
  logic               nrst, ce, cyc, stb, we, go, rd_valid;
  logic               ack, oval, store, spm;
  logic [7:0]         adr, wid, ofs;
  logic [31:0]        wdat, q, rdat;
  logic [3:0]         sel;
  logic [23:0]        rv, rd_data;
  logic signed [31:0] odat;
  int                 err_count = 0;
  int                 total_checks = 0;
  int                 seed = 32'h3cdc;
  int                 stores = 0;
  int                 x, y, z, fac, s0, fs;
  int                 fv[5] = '{99, 100, 99999001, 99999000, 200000};
  bit                 usr;

  always #25 clk = ~clk;
  always @(posedge clk) if (store === 1'b1) stores++;

  pcfg_cmd_interp #(.VER_CODE(VER)) u_dut (
    .i_clk_sys(clk), .i_nrst(nrst), .i_ce(ce), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_out_valid(oval),
    .o_out_data(odat), .o_store(store), .o_setpoint_mode(spm),
    .o_win_width(wid), .o_win_offset(ofs));

  pcfg_rd_src u_src (.i_clk(clk), .i_go(go), .i_val(rv),
    .o_valid(rd_valid), .o_data(rd_data));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // Waits as long as the slave needs; only the watchdog ends a hang.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic rdr(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdr

  // Argument goes first; the opcode write then launches the command.
  task automatic cmd(input pcfg_op_e op, input int arg);
    bus(1'b1, ADDR_ARG, arg);
    bus(1'b1, ADDR_CMD, {27'h0, op});
    repeat (2) @(posedge clk);
  endtask : cmd

  task automatic ucmd(input pcfg_op_e op, input int arg);
    cmd(OP_UNLOCK, 0);
    cmd(op, arg);
  endtask : ucmd

  task automatic trm;
    rdr(ADDR_TRIM, {8'h0, 8'(z), 8'(y), 8'(x)});
  endtask : trm

  task automatic stat(input int b, input logic e);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk({31'h0, q[b]}, {31'h0, e});
    bus(1'b1, ADDR_STATUS, 32'h3);
  endtask : stat

  function automatic logic [31:0] expo(input int raw);
    longint t;
    t = raw + longint'(raw) * (raw >= 0 ? x : y) / 20000
        + longint'(z) * fs / 20000;
    if (usr) t = t * fac / 100000;
    return t[31:0];
  endfunction : expo

  task automatic rdg(input int raw);
    int n;
    go <= 1'b1;
    rv <= raw[23:0];
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (oval !== 1'b1 && n < 10);
    chk({31'h0, oval}, 32'h1);
    chk(odat, expo(raw));
  endtask : rdg

  task automatic clr_trims;
    ucmd(OP_SET_XSLOPE, 0);
    ucmd(OP_SET_YSLOPE, 0);
    ucmd(OP_SET_ZTRIM, 0);
    x = 0;
    y = 0;
    z = 0;
  endtask : clr_trims

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    go = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hf;
    rv = 24'h0;
    x = 0;
    y = 0;
    z = 0;
    fac = FACTOR_ONE;
    fs = int'(FSCALE_RST);
    usr = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdr(ADDR_FACTOR, FACTOR_RST);
    rdr(ADDR_VERSION, {VER, VER_TYPE, VER_LINK, VER_ANALOG});
    rdr(8'hfc, 32'h0);
    ucmd(OP_SET_WIDTH, 60);
    chk(wid, 8'd100);
    ucmd(OP_WIN_PERMIT, 1);
    ucmd(OP_SET_WIDTH, 0);
    chk(wid, 8'd100);
    ucmd(OP_SET_WIDTH, 150);
    chk(wid, 8'd100);
    ucmd(OP_SET_WIDTH, 60);
    chk(wid, 8'd60);
    ucmd(OP_SET_OFFSET, 50);
    chk(ofs, 8'd40);
    ucmd(OP_SET_WIDTH, 80);
    rdr(ADDR_WINDOW, 32'h1450);
    ucmd(OP_SET_WIDTH, -5);
    chk(wid, 8'd80);
    stat(ST_ERR, 1'b1);
    ucmd(OP_SET_WIDTH_SP, 70);
    chk({wid, 7'h0, spm}, {8'd70, 8'h1});
    ucmd(OP_WIN_PERMIT, 0);
    ucmd(OP_SET_WIDTH, 50);
    chk(wid, 8'd70);
    bus(1'b1, ADDR_STATUS, 32'h3);
    cmd(OP_UNLOCK, 0);
    cmd(OP_SET_XSLOPE, 10);
    cmd(OP_SET_XSLOPE, 20);
    x = 10;
    trm;
    stat(ST_REFUSED, 1'b1);
    for (int i = 0; i < 2; i++) begin
      cmd(OP_UNLOCK, 0);
      cmd(i ? OP_FRAME_GROUP : OP_FRAME_STAR, 0);
      cmd(OP_SET_XSLOPE, 30);
      trm;
    end
    cmd(OP_UNLOCK_RAM, 0);
    cmd(OP_SET_XSLOPE, 40);
    cmd(OP_SET_YSLOPE, -40);
    x = 40;
    y = -40;
    trm;
    s0 = stores;
    cmd(OP_PARAM_STORE, 0);
    chk(stores - s0, 0);
    cmd(OP_SET_XSLOPE, 50);
    x = 50;
    trm;
    cmd(OP_UNLOCK, 0);
    cmd(OP_SET_XSLOPE, 60);
    cmd(OP_SET_XSLOPE, 70);
    x = 60;
    trm;
    cmd(OP_UNLOCK_RAM, 0);
    cmd(OP_UNLOCK_OFF, 0);
    cmd(OP_SET_XSLOPE, 80);
    trm;
    s0 = stores;
    ucmd(OP_PARAM_STORE, 0);
    chk(stores - s0, 1);
    ucmd(OP_SET_XSLOPE, 121);
    ucmd(OP_SET_ZTRIM, -121);
    trm;
    stat(ST_ERR, 1'b1);
    repeat (8) begin
      x = $random(seed) % 121;
      y = $random(seed) % 121;
      z = ($random(seed) % 61) * 2;
      ucmd(OP_SET_XSLOPE, x);
      ucmd(OP_SET_YSLOPE, y);
      ucmd(OP_SET_ZTRIM, z);
      trm;
      rdg(20000 * ($random(seed) % 400));
      rdg(20000);
      rdg(-20000);
    end
    for (int i = 0; i < 5; i++) begin
      ucmd(OP_SET_FACTOR, fv[i]);
      if (fv[i] >= FACTOR_MIN && fv[i] <= FACTOR_MAX) fac = fv[i];
      rdr(ADDR_FACTOR, fac);
    end
    rdg(20000);
    ucmd(OP_UNITS_SEL, 1);
    usr = 1'b1;
    rdg(-20000);
    ucmd(OP_UNITS_SEL, 0);
    usr = 1'b0;
    clr_trims;
    rdg(30);
    ucmd(OP_ZERO_CAP, 0);
    z = -60;
    trm;
    rdg(30);
    ucmd(OP_SET_ZTRIM, 0);
    z = 0;
    rdg(30);
    rdg(20000);
    ucmd(OP_ZERO_CAP, 0);
    z = -120;
    trm;
    ucmd(OP_SET_ZTRIM, 0);
    z = 0;
    rdg(-20000);
    ucmd(OP_ZERO_CAP, 0);
    z = 120;
    trm;
    ucmd(OP_SET_ZTRIM, 0);
    z = 0;
    rdg(30);
    ucmd(OP_ORIENT_REF, 0);
    rdr(ADDR_REF, 32'd30);
    rdg(40);
    ucmd(OP_ORIENT_SET, 0);
    z = -20;
    rdg(40);
    ucmd(OP_SET_FSCALE, 20000);
    fs = 20000;
    rdr(ADDR_FSCALE, 32'd20000);
    rdg(40);
    ucmd(OP_ZERO_CAP, 0);
    z = -40;
    trm;
    end_sim;
  end

  initial begin
    #(50 * 40000);
    err_count++;
    end_sim;
  end
endmodule : tb_pressure_config_cmd_interp

// ==== verilog/pcfg_cmd_interp.sv ====
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module pcfg_cmd_interp
  import pcfg_pkg::*;
#(
  // Arbitrary firmware version code.
  parameter logic [7:0] VER_CODE = 8'h11
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_nrst,
  input  wire logic                        i_ce,
  input  wire logic                        i_wb_cyc,
  input  wire logic                        i_wb_stb,
  input  wire logic                        i_wb_we,
  input  wire logic [7:0]                  i_wb_adr,
  input  wire logic [31:0]                 i_wb_dat,
  input  wire logic [3:0]                  i_wb_sel,
  output logic [31:0]                      o_wb_dat,
  output logic                             o_wb_ack,
  input  wire logic                        i_rd_valid,
  input  wire logic signed [pcfg_pkg::RD_W-1:0] i_rd_data,
  output logic                             o_out_valid,
  output logic signed [31:0]               o_out_data,
  output logic                             o_store,
  output logic                             o_setpoint_mode,
  output logic [7:0]                       o_win_width,
  output logic [7:0]                       o_win_offset
);
  import pcfg_pkg::*;

  typedef struct packed {
    logic               ack;
    logic [31:0]        rdat;
    logic signed [31:0] arg;
    logic               err;
    logic               refused;
    logic               one_shot;
    logic               ram_unlock;
    logic               permit;
    logic               user_units;
    logic               setpoint;
    logic [31:0]        factor;
    logic [7:0]         width;
    logic [7:0]         offset;
    logic signed [7:0]  xs;
    logic signed [7:0]  ys;
    logic signed [7:0]  zs;
    logic [FS_W-1:0]    fscale;
    logic signed [31:0] refv;
    logic signed [31:0] last;
    logic               store;
    logic               out_valid;
    logic signed [31:0] out_data;
  } pcfg_state_s;

  pcfg_state_s        st;
  pcfg_state_s        next_st;
  pcfg_op_e           op;
  logic               hit;
  logic               wr;
  logic               ram_ok;
  logic               consume;
  logic [31:0]        rd_mux;
  logic signed [7:0]  slope_trim;
  logic signed [39:0] c_slope;
  logic signed [39:0] c_off;
  logic signed [39:0] c_corr;
  logic signed [71:0] c_user;
  logic signed [31:0] cal_delta;
  logic signed [7:0]  cal_trim;
  logic [7:0]         new_width;

  assign hit = i_wb_cyc && i_wb_stb;
  assign wr  = hit && st.ack && i_wb_we;
  assign op  = (wr && i_wb_adr == ADDR_CMD && i_wb_sel[0]) ?
               pcfg_op_e'(i_wb_dat[4:0]) : OP_NOP;
  assign ram_ok  = st.one_shot || st.ram_unlock;
  assign consume = !(op inside {OP_NOP, OP_UNLOCK, OP_UNLOCK_RAM,
                                OP_UNLOCK_OFF, OP_FRAME_STAR,
                                OP_FRAME_GROUP});

  always_comb begin
    unique case (i_wb_adr)
      ADDR_STATUS:  rd_mux = {25'h0, st.setpoint, st.user_units, st.permit,
                              st.ram_unlock, st.one_shot, st.refused,
                              st.err};
      ADDR_ARG:     rd_mux = st.arg;
      ADDR_FACTOR:  rd_mux = st.factor;
      ADDR_WINDOW:  rd_mux = {16'h0, st.offset, st.width};
      ADDR_TRIM:    rd_mux = {8'h0, st.zs, st.ys, st.xs};
      ADDR_VERSION: rd_mux = {VER_CODE, VER_TYPE, VER_LINK, VER_ANALOG};
      ADDR_FSCALE:  rd_mux = {8'h0, st.fscale};
      ADDR_REF:     rd_mux = st.refv;
      default:      rd_mux = 32'h0;
    endcase
  end

  // Reading correction: slope per sign, then offset, then units.
  always_comb begin
    slope_trim = (i_rd_data >= 0) ? st.xs : st.ys;
    c_slope = 40'(i_rd_data) * 40'(slope_trim);
    c_off   = 40'(st.zs) * $signed({16'h0, st.fscale});
    c_corr  = 40'(i_rd_data) + c_slope / 40'(TRIM_DIV)
              + c_off / 40'(TRIM_DIV);
    c_user  = 72'(c_corr) * $signed({40'h0, st.factor})
              / 72'(FACTOR_ONE);
    cal_delta = (op == OP_ORIENT_SET) ? st.refv - st.last : -st.last;
    new_width = (st.arg == 0 || st.arg > WIDTH_FULL) ?
                8'(WIDTH_FULL) : 8'(st.arg);
  end

  pcfg_trim_calc u_calc (
    .i_base   (st.zs),
    .i_delta  (cal_delta),
    .i_fscale (st.fscale),
    .o_trim   (cal_trim)
  );

  always_comb begin
    next_st           = st;
    next_st.ack       = hit && !st.ack;
    next_st.store     = 1'b0;
    next_st.out_valid = 1'b0;
    if (hit && !st.ack) begin
      next_st.rdat = rd_mux;
    end
    // Flags are set only by a command write and cleared only by a status
    // write; one bus request is never both, so set and clear never meet.
    if (wr && i_wb_adr == ADDR_STATUS && i_wb_sel[0]) begin
      next_st.err     = st.err && !i_wb_dat[ST_ERR];
      next_st.refused = st.refused && !i_wb_dat[ST_REFUSED];
    end
    if (wr && i_wb_adr == ADDR_ARG) begin
      for (int b = 0; b < 4; b++) begin
        if (i_wb_sel[b]) begin
          next_st.arg[8*b +: 8] = i_wb_dat[8*b +: 8];
        end
      end
    end
    // Any configuration or store command spends a pending one-shot
    // unlock, and with it any persistent RAM unlock.
    if (consume) begin
      next_st.one_shot = 1'b0;
      if (st.one_shot) begin
        next_st.ram_unlock = 1'b0;
      end
    end
    if (consume && op != OP_PARAM_STORE && !ram_ok) begin
      next_st.refused = 1'b1;
    end else begin
      unique case (op)
        OP_UNLOCK: begin
          next_st.one_shot   = 1'b1;
          next_st.ram_unlock = 1'b0;
        end
        OP_UNLOCK_RAM: begin
          next_st.ram_unlock = 1'b1;
        end
        OP_UNLOCK_OFF: begin
          next_st.ram_unlock = 1'b0;
          next_st.one_shot   = 1'b0;
        end
        OP_FRAME_STAR, OP_FRAME_GROUP: begin
          next_st.one_shot = 1'b0;
        end
        OP_SET_FACTOR: begin
          if (st.arg < FACTOR_MIN || st.arg > FACTOR_MAX) begin
            next_st.err = 1'b1;
          end else begin
            next_st.factor = st.arg;
          end
        end
        OP_UNITS_SEL: begin
          next_st.user_units = st.arg[0];
        end
        OP_WIN_PERMIT: begin
          next_st.permit = st.arg[0];
        end
        OP_SET_WIDTH, OP_SET_WIDTH_SP: begin
          if (!st.permit) begin
            next_st.refused = 1'b1;
          end else if (st.arg < 0) begin
            next_st.err = 1'b1;
          end else begin
            next_st.width    = new_width;
            next_st.setpoint = (op == OP_SET_WIDTH_SP);
            if (9'(st.offset) + 9'(new_width) > 9'(WIDTH_FULL)) begin
              next_st.offset = 8'(WIDTH_FULL) - new_width;
            end
          end
        end
        OP_SET_OFFSET: begin
          if (st.arg < 0) begin
            next_st.err = 1'b1;
          end else begin
            next_st.offset = (st.arg > OFFSET_MAX) ?
                             8'(OFFSET_MAX) : 8'(st.arg);
            if (9'(next_st.offset) + 9'(st.width) > 9'(WIDTH_FULL)) begin
              next_st.offset = 8'(WIDTH_FULL) - st.width;
            end
          end
        end
        OP_SET_XSLOPE, OP_SET_YSLOPE, OP_SET_ZTRIM: begin
          if (st.arg > TRIM_LIMIT || st.arg < -TRIM_LIMIT) begin
            next_st.err = 1'b1;
          end else if (op == OP_SET_XSLOPE) begin
            next_st.xs = 8'(st.arg);
          end else if (op == OP_SET_YSLOPE) begin
            next_st.ys = 8'(st.arg);
          end else begin
            next_st.zs = 8'(st.arg);
          end
        end
        OP_ZERO_CAP, OP_ORIENT_SET: begin
          next_st.zs = cal_trim;
        end
        OP_ORIENT_REF: begin
          next_st.refv = st.last;
        end
        OP_PARAM_STORE: begin
          if (st.one_shot) begin
            next_st.store = 1'b1;
          end else begin
            next_st.refused = 1'b1;
          end
        end
        OP_SET_FSCALE: begin
          next_st.fscale = st.arg[FS_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (i_rd_valid) begin
      next_st.last      = 32'(c_corr);
      next_st.out_valid = 1'b1;
      next_st.out_data  = st.user_units ? 32'(c_user) : 32'(c_corr);
    end
  end

  // Reset loads the defaults even while the clock enable is low.
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st            <= '0;
      st.factor     <= FACTOR_RST;
      st.width      <= WIDTH_RST;
      st.offset     <= OFFSET_RST;
      st.fscale     <= FSCALE_RST;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_wb_dat        = st.rdat;
  assign o_wb_ack        = st.ack;
  assign o_out_valid     = st.out_valid;
  assign o_out_data      = st.out_data;
  assign o_store         = st.store;
  assign o_setpoint_mode = st.setpoint;
  assign o_win_width     = st.width;
  assign o_win_offset    = st.offset;

  // Checks run on the system clock and rest while reset is held.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  sequence s_plain_unlock;
    i_ce && op == OP_UNLOCK;
  endsequence
  sequence s_consumed;
    i_ce && consume && st.one_shot;
  endsequence

  a_width_range: assert property (st.width >= 8'h01 &&
    st.width <= 8'(WIDTH_FULL)) else $error("window width out of range");
  a_offset_cap: assert property (st.offset <= 8'(OFFSET_MAX))
    else $error("window offset above cap");
  a_window_top: assert property (
    9'(st.offset) + 9'(st.width) <= 9'(WIDTH_FULL))
    else $error("window top exceeds output limit");
  a_trim_range: assert property (
    st.zs <= 8'(TRIM_LIMIT) && st.zs >= 8'(-TRIM_LIMIT) &&
    st.xs <= 8'(TRIM_LIMIT) && st.xs >= 8'(-TRIM_LIMIT) &&
    st.ys <= 8'(TRIM_LIMIT) && st.ys >= 8'(-TRIM_LIMIT))
    else $error("trim outside range");
  a_bad_trim_err: assert property (i_ce && ram_ok &&
    op == OP_SET_ZTRIM && (st.arg > TRIM_LIMIT || st.arg < -TRIM_LIMIT)
    |=> st.err && $stable(st.zs))
    else $error("bad trim not flagged");
  a_unlock_arm: assert property (s_plain_unlock
    |=> st.one_shot && !st.ram_unlock) else $error("unlock not armed");
  a_unlock_once: assert property (s_consumed
    |=> !st.one_shot && !st.ram_unlock) else $error("unlock not spent");
  a_store_gate: assert property (o_store |->
    $past(st.one_shot) && $past(op) == OP_PARAM_STORE)
    else $error("store without plain unlock");
  a_cancel_ram: assert property (i_ce && op == OP_UNLOCK_OFF
    |=> !st.ram_unlock) else $error("ram unlock survived cancel");
  a_frame_cancel: assert property (i_ce && (op == OP_FRAME_STAR ||
    op == OP_FRAME_GROUP) |=> !st.one_shot)
    else $error("frame did not cancel unlock");
  a_permit_gate: assert property (i_ce && !st.permit &&
    op == OP_SET_WIDTH |=> $stable(st.width) && st.refused)
    else $error("width changed without permit");
  a_factor_range: assert property (st.factor >= 32'(FACTOR_MIN) &&
    st.factor <= 32'(FACTOR_MAX)) else $error("unit factor out of range");
  a_units_plain: assert property (i_ce && i_rd_valid &&
    !st.user_units |=> o_out_data == 32'($past(c_corr)))
    else $error("factor applied without user units");
  a_bus_ack: assert property (i_ce && hit && !st.ack |=> o_wb_ack ##1
    (!o_wb_ack || !$past(i_ce))) else $error("ack not one cycle");
  a_width_clamp: assert property (i_ce && ram_ok && st.permit &&
    op inside {OP_SET_WIDTH, OP_SET_WIDTH_SP} &&
    (st.arg == 0 || st.arg > WIDTH_FULL) |=> o_win_width == 8'(WIDTH_FULL))
    else $error("width entry not clamped to full span");
  a_setpoint_sel: assert property (i_ce && ram_ok && st.permit &&
    st.arg >= 0 && op == OP_SET_WIDTH_SP |=> o_setpoint_mode)
    else $error("setpoint option not applied");
  a_store_refused: assert property (i_ce && !st.one_shot &&
    op == OP_PARAM_STORE |=> !o_store && st.refused)
    else $error("store allowed without plain unlock");

endmodule : pcfg_cmd_interp

// ==== verilog/pcfg_pkg.sv ====
package pcfg_pkg;

  localparam int RD_W = 24;
  localparam int FS_W = 24;

  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_CMD     = 8'h04;
  localparam logic [7:0] ADDR_ARG     = 8'h08;
  localparam logic [7:0] ADDR_FACTOR  = 8'h0c;
  localparam logic [7:0] ADDR_WINDOW  = 8'h10;
  localparam logic [7:0] ADDR_TRIM    = 8'h14;
  localparam logic [7:0] ADDR_VERSION = 8'h18;
  localparam logic [7:0] ADDR_FSCALE  = 8'h1c;
  localparam logic [7:0] ADDR_REF     = 8'h20;

  localparam int ST_ERR        = 0;
  localparam int ST_REFUSED    = 1;
  localparam int ST_ONE_SHOT   = 2;
  localparam int ST_RAM_UNLOCK = 3;
  localparam int ST_PERMIT     = 4;
  localparam int ST_USER_UNITS = 5;
  localparam int ST_SETPOINT   = 6;

  // Unit factor is held in steps of 0.00001.
  localparam int FACTOR_MIN = 100;
  localparam int FACTOR_MAX = 99999000;
  localparam int FACTOR_ONE = 100000;
  localparam logic [31:0] FACTOR_RST = 32'h000186a0;

  // One trim step is 0.00005, so the divisor is its inverse.
  localparam int TRIM_LIMIT = 120;
  localparam int TRIM_DIV   = 20000;

  localparam int WIDTH_FULL = 100;
  localparam int OFFSET_MAX = 40;
  localparam logic [7:0] WIDTH_RST  = 8'h64;
  localparam logic [7:0] OFFSET_RST = 8'h00;
  localparam logic [FS_W-1:0] FSCALE_RST = 24'h002710;

  localparam logic [7:0] VER_TYPE   = 8'h53;
  localparam logic [7:0] VER_LINK   = 8'h32;
  localparam logic [7:0] VER_ANALOG = 8'h56;

  typedef enum logic [4:0] {
    OP_NOP         = 5'h00,
    OP_UNLOCK      = 5'h01,
    OP_UNLOCK_RAM  = 5'h02,
    OP_UNLOCK_OFF  = 5'h03,
    OP_FRAME_STAR  = 5'h04,
    OP_FRAME_GROUP = 5'h05,
    OP_SET_FACTOR  = 5'h06,
    OP_UNITS_SEL   = 5'h07,
    OP_WIN_PERMIT  = 5'h08,
    OP_SET_WIDTH   = 5'h09,
    OP_SET_WIDTH_SP = 5'h0a,
    OP_SET_OFFSET  = 5'h0b,
    OP_SET_XSLOPE  = 5'h0c,
    OP_SET_YSLOPE  = 5'h0d,
    OP_SET_ZTRIM   = 5'h0e,
    OP_ZERO_CAP    = 5'h0f,
    OP_ORIENT_REF  = 5'h10,
    OP_ORIENT_SET  = 5'h11,
    OP_PARAM_STORE = 5'h12,
    OP_SET_FSCALE  = 5'h13
  } pcfg_op_e;

endpackage : pcfg_pkg

// ==== verilog/pcfg_trim_calc.sv ====
`timescale 1ns/1ps
// Works out a saturated offset trim that moves a reading by i_delta.
module pcfg_trim_calc
  import pcfg_pkg::*;
(
  input  wire logic signed [7:0]  i_base,
  input  wire logic signed [31:0] i_delta,
  input  wire logic [pcfg_pkg::FS_W-1:0] i_fscale,
  output logic signed [7:0]       o_trim
);
  import pcfg_pkg::*;

  logic signed [47:0] num;
  logic signed [47:0] quo;
  logic signed [47:0] sum;

  always_comb begin
    num = 48'(i_delta) * 48'(TRIM_DIV);
    quo = (i_fscale == '0) ? 48'sd0 : num / $signed({24'h0, i_fscale});
    sum = quo + 48'(i_base);
    if (sum > 48'(TRIM_LIMIT)) begin
      o_trim = 8'(TRIM_LIMIT);
    end else if (sum < -48'(TRIM_LIMIT)) begin
      o_trim = 8'(-TRIM_LIMIT);
    end else begin
      o_trim = 8'(sum);
    end
  end
endmodule : pcfg_trim_calc
